// >>> src/cpu_group_params.svh
// constants of the call, compare, skip and flag instruction group: offsets, fields, resets, encodings
// assumes it is included by its bare name wherever these macros are needed
`ifndef CPU_GROUP_PARAMS_SVH
`define CPU_GROUP_PARAMS_SVH

// apb byte offsets
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_PC_SP       8'h08
`define OFS_INT_PRIO    8'h0c

// control register fields
`define CTRL_RUN_BIT    0
`define CTRL_RBE_BIT    1
`define CTRL_MBE_BIT    2
`define CTRL_RESET      3'h0

// interrupt priority register fields
`define PRIO_MASTER_EN_BIT 3
`define PRIO_RESET         3'h0

// core reset values and stack frame
`define PC_RESET        15'h0000
`define SP_RESET        8'h00
`define SP_FRAME        8'h06
`define CALLS_PAGE_CLR  4'h0

// register file slots
`define R_A             3'h0
`define R_E             3'h1
`define R_L             3'h2
`define R_H             3'h3

// first byte encodings
`define OP_CALLS_HI     5'h1d
`define OP_CALL_LONG    8'hdb
`define OP_INCS_DIRECT  8'hca
`define OP_CARRY_CMPL   8'hd6
`define OP_CMP_A_MEM    8'h38
`define OP_DEC_R_HI     5'h09
`define OP_PFX_RIM      8'hd9
`define OP_PFX_DD       8'hdd
`define OP_PFX_DC       8'hdc
`define OP_INT_OFF      8'hfe
`define OP_INT_ON       8'hff

// second byte encodings
`define B2_ACC_CMPL     8'h3f
`define B2_MEM_IM_HI    4'h7
`define B2_ACC_REG_HI   5'h0d
`define B2_XACC_MEM     8'h09
`define B2_XACC_PAIR_HI 5'h1d
`define B2_DEC_PAIR_HI  5'h1b
`define B2_INT          8'hb2

// timing: index of the last cycle of a short call (three cycles, counted from zero)
`define CALLS_LAST_CYC  3'h2

`endif

// >>> src/cpu_group_pkg.sv
// types shared by the instruction group core and its register file
// assumes nothing beyond a SystemVerilog compiler
package cpu_group_pkg;

	typedef enum logic [2:0] {
		ST_FETCH,
		ST_BYTE2,
		ST_CALL,
		ST_SKIP_HEAD,
		ST_SKIP_TAIL
	} core_state_e;

	typedef struct packed {
		core_state_e st;
		logic [14:0] pc;
		logic [7:0]  sp;
		logic [7:0]  op;
		logic [7:0]  tgt;
		logic        carry;
		logic        master_interrupt_enable;
		logic [2:0]  prio;
		logic        run;
		logic        rbe;
		logic        mbe;
		logic        lo_match;
		logic [1:0]  skip_left;
		logic [2:0]  cyc;
		logic [31:0] prdata;
		logic        stack_we;
		logic [7:0]  stack_addr;
		logic [23:0] frame;
		logic        unknown;
	} core_s;

	typedef struct packed {
		logic [7:0][3:0] nib;
	} rf_s;

endpackage : cpu_group_pkg

// >>> src/nib_rf_if.sv
// carrier between the core and its nibble register file
// assumes a single clock domain; the file owner registers writes
`timescale 1ns/1ps
`default_nettype none

interface nib_rf_if;
	logic [7:0][3:0] rdata;
	logic [7:0]      we;
	logic [7:0][3:0] wdata;

	modport owner (input we, input wdata, output rdata);
	modport user  (output we, output wdata, input rdata);
endinterface : nib_rf_if

`default_nettype wire

// >>> src/nibble_regfile.sv
// eight four-bit working registers with per-entry write enables
// assumes writes come from one owner per cycle; read data comes straight from the flops
`timescale 1ns/1ps
`default_nettype none

module nibble_regfile #(
	parameter int DEPTH = 8
) (
	input  wire logic clk,
	input  wire logic srst,
	nib_rf_if.owner   rf
);
	cpu_group_pkg::rf_s q;
	cpu_group_pkg::rf_s d;
	logic [7:0][3:0]    nxt;

	// the pair and slot encodings only address eight entries
	generate
		if (DEPTH != 8)
		begin : g_bad_depth
			$error("register file depth must be eight");
		end
	endgenerate

	// next value per entry
	for (genvar i = 0; i < DEPTH; i++)
	begin : g_ent
		assign nxt[i] = rf.we[i] ? rf.wdata[i] : q.nib[i];
	end

	always_comb
	begin
		d = q;
		d.nib = nxt;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			q <= '0;
		else
			q <= d;
	end

	assign rf.rdata = q.nib;
endmodule : nibble_regfile

`default_nettype wire

// >>> src/cpu_call_compare_flag_ops.sv
// execution core for the short call, carry and accumulator complement, compare-skip,
// decrement-skip and interrupt enable/disable instructions, with an apb status port
// assumes program and data memory answer combinationally in the cycle their address is shown
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_group_params.svh"

module cpu_call_compare_flag_ops #(
	parameter int APB_AW = 8
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	output logic [14:0]            prog_addr,
	input  wire logic [7:0]        prog_byte,
	output logic [7:0]             data_addr,
	input  wire logic [3:0]        data_rdata,
	output logic                   stack_we,
	output logic [7:0]             stack_addr,
	output logic [23:0]            stack_frame,
	input  wire logic              int_pending,
	output logic                   int_vector_req,
	output logic                   instr_start,
	output logic                   unknown_op
);
	cpu_group_pkg::core_s q;
	cpu_group_pkg::core_s d;
	logic [7:0][3:0]      regs;
	logic [7:0][3:0]      rf_wdata;
	logic [7:0]           rf_we;
	logic [7:0]           pointer_pair;
	logic [7:0]           extended_accumulator;
	logic                 apb_setup;
	logic                 apb_write;
	logic                 hit_ctrl;
	logic                 hit_status;
	logic                 hit_pc;
	logic                 hit_prio;
	logic                 hit_any;
	logic [31:0]          rd_mux;
	logic                 is_two_byte;
	logic                 exec_carry_cmpl;
	logic                 exec_com;
	logic                 exec_cmp;
	logic                 exec_dec_skip;
	logic                 exec_int_dis;
	logic                 exec_int_en;
	logic                 exec_calls;
	logic                 take_skip;
	logic                 borrow;
	logic [2:0]           sel_r;
	logic [1:0]           sel_p;
	logic [7:0]           pair_v;
	logic [1:0]           skip_len;

	// the map needs at least the low five address bits
	generate
		if (APB_AW < 5)
		begin : g_bad_aw
			$error("apb address too narrow for the register map");
		end
	endgenerate

	nib_rf_if rf ();

	nibble_regfile #(
		.DEPTH (8)
	) u_rf (
		.clk  (clk),
		.srst (srst),
		.rf   (rf)
	);

	assign regs                 = rf.rdata;
	assign rf.we                = rf_we;
	assign rf.wdata             = rf_wdata;
	assign pointer_pair         = {regs[`R_H], regs[`R_L]};
	assign extended_accumulator = {regs[`R_E], regs[`R_A]};

	// length of the instruction being stepped over; unknown first bytes count as one byte
	function automatic logic [1:0] instr_len(input logic [7:0] b);
		logic [1:0] n;
		n = 2'h1;
		if (b == `OP_CALL_LONG)
			n = 2'h3;
		else if (b[7:3] == `OP_CALLS_HI || b == `OP_PFX_RIM || b == `OP_PFX_DD || b == `OP_PFX_DC
				|| b == `OP_INT_OFF || b == `OP_INT_ON || b == `OP_INCS_DIRECT)
			n = 2'h2;
		return n;
	endfunction : instr_len

	// apb decode; zero wait states, so pready is constant high
	assign apb_setup  = psel && !penable;
	assign apb_write  = psel && penable && pwrite && hit_any;
	assign hit_ctrl   = (paddr == APB_AW'(`OFS_CTRL));
	assign hit_status = (paddr == APB_AW'(`OFS_STATUS));
	assign hit_pc     = (paddr == APB_AW'(`OFS_PC_SP));
	assign hit_prio   = (paddr == APB_AW'(`OFS_INT_PRIO));
	assign hit_any    = hit_ctrl || hit_status || hit_pc || hit_prio;
	assign pready     = 1'b1;
	assign pslverr    = psel && penable && !hit_any;
	assign prdata     = q.prdata;

	// read mux, sampled in the setup cycle so the data leaves a flop
	assign rd_mux = hit_ctrl   ? {29'h0000_0000, q.mbe, q.rbe, q.run} :
			hit_status ? {24'h00_0000, (q.st == cpu_group_pkg::ST_SKIP_HEAD || q.st == cpu_group_pkg::ST_SKIP_TAIL),
				(q.st != cpu_group_pkg::ST_FETCH), q.master_interrupt_enable, q.carry, regs[`R_A]} :
			hit_pc     ? {9'h000, q.sp, q.pc} :
			hit_prio   ? {28'h000_0000, q.master_interrupt_enable, q.prio} :
			32'h0000_0000;

	assign is_two_byte = (prog_byte[7:3] == `OP_CALLS_HI) || (prog_byte == `OP_PFX_RIM)
			|| (prog_byte == `OP_PFX_DD) || (prog_byte == `OP_PFX_DC)
			|| (prog_byte == `OP_INT_OFF) || (prog_byte == `OP_INT_ON);

	// memory operand is at the pointer, except the second nibble of the extended compare
	assign data_addr = pointer_pair + ((q.st == cpu_group_pkg::ST_BYTE2 && q.op == `OP_PFX_DC) ? 8'h01 : 8'h00);

	// next-state logic: apb side first, so an instruction in the same cycle wins the master enable
	always_comb
	begin
		d = q;
		d.stack_we = 1'b0;
		d.unknown = 1'b0;
		rf_we = 8'h00;
		rf_wdata = regs;
		exec_carry_cmpl = 1'b0;
		exec_com = 1'b0;
		exec_cmp = 1'b0;
		exec_dec_skip = 1'b0;
		exec_int_dis = 1'b0;
		exec_int_en = 1'b0;
		exec_calls = 1'b0;
		take_skip = 1'b0;
		borrow = 1'b0;
		sel_r = 3'h0;
		sel_p = 2'h0;
		pair_v = 8'h00;
		skip_len = instr_len(prog_byte);
		if (apb_setup && !pwrite)
			d.prdata = rd_mux;
		if (apb_write && hit_ctrl)
		begin
			d.run = pwdata[`CTRL_RUN_BIT];
			d.rbe = pwdata[`CTRL_RBE_BIT];
			d.mbe = pwdata[`CTRL_MBE_BIT];
		end
		if (apb_write && hit_prio)
		begin
			d.prio = pwdata[2:0];
			d.master_interrupt_enable = pwdata[`PRIO_MASTER_EN_BIT];
		end
		case (q.st)
			cpu_group_pkg::ST_FETCH:
				if (q.run)
				begin
					d.op = prog_byte;
					d.pc = q.pc + 15'h0001;
					d.lo_match = (regs[`R_A] == data_rdata);
					if (is_two_byte)
						d.st = cpu_group_pkg::ST_BYTE2;
					else if (prog_byte == `OP_CARRY_CMPL)
					begin
						exec_carry_cmpl = 1'b1;
						d.carry = ~q.carry;
					end
					else if (prog_byte == `OP_CMP_A_MEM)
					begin
						exec_cmp = 1'b1;
						take_skip = (regs[`R_A] == data_rdata);
					end
					else if (prog_byte[7:3] == `OP_DEC_R_HI)
					begin
						exec_dec_skip = 1'b1;
						sel_r = prog_byte[2:0];
						borrow = (regs[sel_r] == 4'h0);
						rf_we[sel_r] = 1'b1;
						rf_wdata[sel_r] = regs[sel_r] - 4'h1;
						take_skip = borrow;
					end
					else
						d.unknown = 1'b1;
					if (take_skip)
						d.st = cpu_group_pkg::ST_SKIP_HEAD;
				end
			cpu_group_pkg::ST_BYTE2:
			begin
				d.pc = q.pc + 15'h0001;
				d.st = cpu_group_pkg::ST_FETCH;
				if (q.op[7:3] == `OP_CALLS_HI)
				begin
					d.tgt = prog_byte;
					d.st = cpu_group_pkg::ST_CALL;
				end
				else
				begin
					case (q.op)
						`OP_PFX_RIM:
							if (!prog_byte[3])
							begin
								exec_cmp = 1'b1;
								take_skip = (regs[prog_byte[2:0]] == prog_byte[7:4]);
							end
							else
								d.unknown = 1'b1;
						`OP_PFX_DD:
							if (prog_byte == `B2_ACC_CMPL)
							begin
								exec_com = 1'b1;
								rf_we[`R_A] = 1'b1;
								rf_wdata[`R_A] = ~regs[`R_A];
							end
							else if (prog_byte[7:4] == `B2_MEM_IM_HI)
							begin
								exec_cmp = 1'b1;
								take_skip = (data_rdata == prog_byte[3:0]);
							end
							else if (prog_byte[7:3] == `B2_ACC_REG_HI)
							begin
								exec_cmp = 1'b1;
								take_skip = (regs[`R_A] == regs[prog_byte[2:0]]);
							end
							else
								d.unknown = 1'b1;
						`OP_PFX_DC:
							if (prog_byte == `B2_XACC_MEM)
							begin
								exec_cmp = 1'b1;
								take_skip = q.lo_match && (regs[`R_E] == data_rdata);
							end
							else if (prog_byte[7:3] == `B2_XACC_PAIR_HI && !prog_byte[0])
							begin
								exec_cmp = 1'b1;
								sel_p = prog_byte[2:1];
								pair_v = {regs[{sel_p, 1'b1}], regs[{sel_p, 1'b0}]};
								take_skip = (extended_accumulator == pair_v);
							end
							else if (prog_byte[7:3] == `B2_DEC_PAIR_HI && !prog_byte[0])
							begin
								exec_dec_skip = 1'b1;
								sel_p = prog_byte[2:1];
								pair_v = {regs[{sel_p, 1'b1}], regs[{sel_p, 1'b0}]};
								borrow = (pair_v == 8'h00);
								rf_we[{sel_p, 1'b1}] = 1'b1;
								rf_we[{sel_p, 1'b0}] = 1'b1;
								{rf_wdata[{sel_p, 1'b1}], rf_wdata[{sel_p, 1'b0}]} = pair_v - 8'h01;
								take_skip = borrow;
							end
							else
								d.unknown = 1'b1;
						`OP_INT_OFF:
							if (prog_byte == `B2_INT)
							begin
								exec_int_dis = 1'b1;
								d.master_interrupt_enable = 1'b0;
							end
							else
								d.unknown = 1'b1;
						`OP_INT_ON:
							if (prog_byte == `B2_INT)
							begin
								exec_int_en = 1'b1;
								d.master_interrupt_enable = 1'b1;
							end
							else
								d.unknown = 1'b1;
						default:
							d.unknown = 1'b1;
					endcase
				end
				if (take_skip)
					d.st = cpu_group_pkg::ST_SKIP_HEAD;
			end
			cpu_group_pkg::ST_CALL:
			begin
				// q.pc already points past the second byte: that is the return address
				exec_calls = 1'b1;
				d.pc = {`CALLS_PAGE_CLR, q.op[2:0], q.tgt};
				d.sp = q.sp - `SP_FRAME;
				d.stack_addr = q.sp - `SP_FRAME;
				d.stack_we = 1'b1;
				d.frame = {4'h0, 2'h0, q.mbe, q.rbe, q.pc[7:4], q.pc[3:0], 1'h0, q.pc[14:12], q.pc[11:8]};
				d.st = cpu_group_pkg::ST_FETCH;
			end
			cpu_group_pkg::ST_SKIP_HEAD:
			begin
				// one cycle per skipped byte, so a skip costs as many cycles as the bytes it hides
				d.pc = q.pc + 15'h0001;
				if (skip_len == 2'h1)
					d.st = cpu_group_pkg::ST_FETCH;
				else
				begin
					d.skip_left = skip_len - 2'h1;
					d.st = cpu_group_pkg::ST_SKIP_TAIL;
				end
			end
			cpu_group_pkg::ST_SKIP_TAIL:
			begin
				d.pc = q.pc + 15'h0001;
				d.skip_left = q.skip_left - 2'h1;
				if (q.skip_left == 2'h1)
					d.st = cpu_group_pkg::ST_FETCH;
			end
			default:
				d.st = cpu_group_pkg::ST_FETCH;
		endcase
		d.cyc = (d.st == cpu_group_pkg::ST_FETCH) ? 3'h0 : q.cyc + 3'h1;
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			q <= '0;
			q.st <= cpu_group_pkg::ST_FETCH;
			q.pc <= `PC_RESET;
			q.sp <= `SP_RESET;
			q.prio <= `PRIO_RESET;
			{q.mbe, q.rbe, q.run} <= `CTRL_RESET;
		end
		else
			q <= d;
	end

	// outputs; the vector request is a level so the interrupt logic can hold its latches meanwhile
	assign prog_addr      = q.pc;
	assign stack_we       = q.stack_we;
	assign stack_addr     = q.stack_addr;
	assign stack_frame    = q.frame;
	assign int_vector_req = q.master_interrupt_enable && int_pending;
	assign instr_start    = (q.st == cpu_group_pkg::ST_FETCH) && q.run;
	assign unknown_op     = q.unknown;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	calls_cycles_a: assert property (exec_calls |-> q.cyc == `CALLS_LAST_CYC && $past(q.st, 2) == cpu_group_pkg::ST_FETCH)
		else $error("short call did not take three cycles");
	calls_target_a: assert property (exec_calls |=> q.pc == {4'h0, $past(q.op[2:0]), $past(q.tgt)})
		else $error("short call target wrong");
	calls_ret_a: assert property (exec_calls |=> stack_we && {stack_frame[6:4], stack_frame[3:0], stack_frame[15:12],
			stack_frame[11:8]} == $past(q.pc))
		else $error("short call return address wrong");
	frame_zero_a: assert property (stack_we |-> stack_frame[23:18] == 6'h00 && !stack_frame[7])
		else $error("stack frame zero nibbles wrong");
	sp_drop_a: assert property (stack_we |-> q.sp == $past(q.sp) - 8'h06 && stack_addr == q.sp)
		else $error("stack pointer not lowered by six");
	carry_flip_a: assert property (exec_carry_cmpl |=> q.carry != $past(q.carry))
		else $error("carry not inverted");
	acc_invert_a: assert property (exec_com |=> regs[`R_A] == ~$past(regs[`R_A]))
		else $error("accumulator not inverted");
	cmp_keep_a: assert property (exec_cmp |-> rf_we == 8'h00)
		else $error("compare wrote an operand");
	dec_carry_a: assert property (exec_dec_skip |=> $stable(q.carry))
		else $error("decrement changed carry");
	dec_skip_a: assert property (exec_dec_skip && q.st == cpu_group_pkg::ST_FETCH |=>
			(q.st == cpu_group_pkg::ST_SKIP_HEAD) == (regs[$past(prog_byte[2:0])] == 4'hf))
		else $error("decrement skip does not follow the wrap");
	int_off_a: assert property (exec_int_dis && !apb_write |=> !q.master_interrupt_enable ##1
			(q.master_interrupt_enable == $past(q.master_interrupt_enable) || $past(apb_write)))
		else $error("master enable not cleared");
	int_on_a: assert property (exec_int_en |=> q.master_interrupt_enable)
		else $error("master enable not set");
	vector_gate_a: assert property (!q.master_interrupt_enable |-> !int_vector_req)
		else $error("vector requested while disabled");
	skip_steps_a: assert property (take_skip |=> q.st == cpu_group_pkg::ST_SKIP_HEAD ##1 q.pc == $past(q.pc) + 15'h0001)
		else $error("skip did not step over the next byte");
endmodule : cpu_call_compare_flag_ops

`default_nettype wire

// >>> verif/far_side_model.sv
// far side of the core: program rom, nibble data memory and the pending interrupt line
// assumes the bench loads rom, ram and pend directly; both memories answer in the same cycle
`timescale 1ns/1ps
`default_nettype none

module far_side_model (
	input  wire logic [14:0] prog_addr,
	output logic      [7:0]  prog_byte,
	input  wire logic [7:0]  data_addr,
	output logic      [3:0]  data_rdata,
	output logic             int_pending
);
	logic [7:0] rom [0:32767];
	logic [3:0] ram [0:255];
	logic       pend;

	// combinational answers: the core consumes the byte in the cycle its address shows
	assign prog_byte   = rom[prog_addr];
	assign data_rdata  = ram[data_addr];
	assign int_pending = pend; // level, as a latched and enabled source would hold it
endmodule : far_side_model

`default_nettype wire

// >>> verif/cpu_call_compare_flag_ops_tb.sv
// self-checking bench for the call, compare, skip and flag instruction core
// assumes far_side_model as memories; registers are reached over apb with the header's offsets
`timescale 1ns/1ps
`default_nettype none
`include "cpu_group_params.svh"

module cpu_call_compare_flag_ops_tb;
	typedef struct packed {
		logic [31:0] e;
		logic [31:0] m;
		logic        er;
	} note_s;

	logic        clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, data_addr, stack_addr, prog_byte;
	logic [31:0] pwdata, prdata, seed, ctrl_v, prio_v;
	logic [14:0] prog_addr;
	logic [3:0]  data_rdata;
	logic [23:0] stack_frame;
	logic        stack_we, int_pending, int_vector_req, instr_start, unknown_op;
	logic [10:0] tgt;
	logic [7:0]  prog [31];
	note_s       rq [$];
	note_s       nt;
	logic [46:0] sq [$];
	int          fails, n_checks, n_stack, i, n_cyc, n_start, n_unk;

	cpu_call_compare_flag_ops #(.APB_AW(8)) dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.prog_addr(prog_addr), .prog_byte(prog_byte), .data_addr(data_addr), .data_rdata(data_rdata),
		.stack_we(stack_we), .stack_addr(stack_addr), .stack_frame(stack_frame), .int_pending(int_pending),
		.int_vector_req(int_vector_req), .instr_start(instr_start), .unknown_op(unknown_op));

	far_side_model mem_u (.prog_addr(prog_addr), .prog_byte(prog_byte), .data_addr(data_addr),
		.data_rdata(data_rdata), .int_pending(int_pending));

	// 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic results();
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	// one apb transfer; the expected read data, mask and error flag are noted at setup
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
		input logic [31:0] m, input logic er);
		int k;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		rq.push_back('{e, m, er});
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
		begin
			fails++; // a bus that never answers counts as a mismatch
			results();
		end
		else
		begin
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	// takes the oldest note whenever a transfer completes, and the oldest expected frame whenever the core writes a stack frame
	always @(posedge clk)
	begin
		n_cyc++;
		if (psel && penable && pready === 1'b1)
		begin
			nt = rq.pop_front();
			chk(prdata & nt.m, nt.e);
			chk(pslverr, nt.er);
			if (pwrite && paddr == `OFS_CTRL)
				n_cyc = 0; // cycles count from the edge that sets run
		end
		if (stack_we === 1'b1)
		begin
			chk(sq.size() == 0, 1'b0);
			chk({stack_addr, stack_frame, prog_addr}, sq.pop_front());
			chk(n_cyc, 35);
			chk(n_start, 15);
			chk(n_unk, 0);
			n_stack++;
		end
		if (instr_start === 1'b1)
			n_start++;
		if (unknown_op === 1'b1)
			n_unk++;
	end

	initial
	begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		fails = 0;
		n_checks = 0;
		n_stack = 0;
		n_cyc = 0;
		n_start = 0;
		n_unk = 0;
		seed = 32'h4e;
		mem_u.pend = 1'b1;
		for (i = 0; i < 32768; i++)
			mem_u.rom[i] = 8'h0; // unknown one-byte ops pad the whole space
		for (i = 0; i < 256; i++)
			mem_u.ram[i] = 4'h0;
		// carry flip, acc invert, dec, cmp skip, dec borrow skip, enable, ext cmp skip, then reg/imm,
		// mem/imm, acc/reg (unequal: both carry flips run), pair compare and pair borrow skips
		prog = '{8'hd6, 8'hdd, 8'h3f, 8'h48, 8'h38, 8'hfe, 8'hb2, 8'h49, 8'hd6, 8'hff, 8'hb2, 8'hdc, 8'h09,
			8'hfe, 8'hb2, 8'hd9, 8'hf1, 8'hd6, 8'hdd, 8'h7e, 8'hd6, 8'hdd, 8'h69, 8'hd6, 8'hd6, 8'hdc, 8'he8,
			8'hd6, 8'hdc, 8'hda, 8'hd6};
		for (i = 0; i < 31; i++)
			mem_u.rom[i] = prog[i];
		tgt = 11'd64 + 11'(rnd() % 32'd1900); // clear of the program and inside the eleven-bit call reach
		mem_u.rom[31] = {5'b11101, tgt[10:8]};
		mem_u.rom[32] = tgt[7:0];
		mem_u.ram[0] = 4'he;
		mem_u.ram[1] = 4'hf;
		ctrl_v = {29'h0, rnd() % 32'd4 == 0 ? 2'b11 : rnd() % 32'd2 == 0 ? 2'b01 : 2'b10, 1'b1};
		prio_v = rnd() & 32'h7;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		// reset values, then the refusal of an unmapped place
		apb(1'b0, `OFS_CTRL, 32'h0, 32'h0, 32'h7, 1'b0);
		apb(1'b0, `OFS_STATUS, 32'h0, 32'h0, 32'hff, 1'b0);
		apb(1'b0, `OFS_PC_SP, 32'h0, 32'h0, 32'h7f_ffff, 1'b0);
		apb(1'b0, `OFS_INT_PRIO, 32'h0, 32'h0, 32'hf, 1'b0);
		apb(1'b1, 8'h10, rnd(), 32'h0, 32'h0, 1'b1);
		apb(1'b0, 8'h10, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
		apb(1'b1, `OFS_INT_PRIO, prio_v, 32'h0, 32'h0, 1'b0);
		// return address 33 split over the frame, bank enables beside it, sp lowered to fa
		sq.push_back({8'hfa, 6'h0, ctrl_v[2:1], 16'h2100, 4'h0, tgt});
		apb(1'b1, `OFS_CTRL, ctrl_v, 32'h0, 32'h0, 1'b0);
		for (i = 0; i < 300 && n_stack == 0; i++)
			@(posedge clk);
		chk(n_stack, 1);
		apb(1'b1, `OFS_CTRL, ctrl_v & 32'h6, 32'h0, 32'h0, 1'b0);
		apb(1'b0, `OFS_STATUS, 32'h0, 32'h3e, 32'hff, 1'b0);
		apb(1'b0, `OFS_PC_SP, 32'h0, 32'h7d_0000, 32'h7f_8000, 1'b0);
		apb(1'b0, `OFS_INT_PRIO, 32'h0, prio_v | 32'h8, 32'hf, 1'b0);
		apb(1'b0, `OFS_CTRL, 32'h0, ctrl_v & 32'h6, 32'h7, 1'b0);
		chk(int_vector_req, 1'b1);
		// the routine area becomes disable ops; whatever byte the pc sits on, one runs soon
		for (i = 0; i < 64; i++)
			mem_u.rom[tgt + 11'(i)] = i[0] ? 8'hb2 : 8'hfe;
		apb(1'b1, `OFS_CTRL, ctrl_v, 32'h0, 32'h0, 1'b0);
		repeat (20) @(posedge clk);
		apb(1'b1, `OFS_CTRL, ctrl_v & 32'h6, 32'h0, 32'h0, 1'b0);
		apb(1'b0, `OFS_STATUS, 32'h0, 32'h1e, 32'h3f, 1'b0);
		apb(1'b0, `OFS_INT_PRIO, 32'h0, prio_v, 32'hf, 1'b0);
		chk(int_vector_req, 1'b0);
		chk(instr_start, 1'b0);
		chk(n_unk != 0, 1'b1);
		results();
	end
endmodule : cpu_call_compare_flag_ops_tb

`default_nettype wire
